// ==== hdl/rrsa_alu.sv ====
/*
  datapath for the right rotates and subtract-with-borrow of an 8-bit core.
  holds the working register and the status flags; memory is outside and
  is written through the registered mem_wr answer one cycle after a request.
  assumes requests and loads are synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [RULE_01] Plain rotate to the working register loads bit i from memory bit i+1 and bit 7 from memory bit 0.
// [RULE_02] Plain rotate to the working register writes no memory and changes no flag.
// [RULE_03] Rotate through carry to memory writes the rotated byte back to the addressed location.
// [RULE_04] In that rotate old carry goes to bit 7, bits shift down, carry takes old bit 0, no other flag moves.
// [RULE_05] Rotate through carry to the working register takes bits from memory i+1, bit 7 from carry, carry from bit 0.
// [RULE_06] Rotate through carry to the working register leaves memory alone and moves only carry.
// [RULE_07] Subtract with borrow stores work minus memory minus inverted carry in the working register only.
// [RULE_08] After subtract with borrow carry is 0 on a negative result and 1 on zero or positive.
// [RULE_09] Subtract with borrow updates wrap, zero, nibble borrow, carry, signed and extended nil flags.
module rrsa_alu (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  clk_en,
  input  wire rrsa_pkg::rrsa_req_t   req,
  input  wire rrsa_pkg::rrsa_load_t  load,
  output var  logic [7:0]            work_reg,
  output var  rrsa_pkg::rrsa_flags_t flags,
  output var  rrsa_pkg::rrsa_mem_wr_t mem_wr
);
  import rrsa_pkg::*;

  // ==========================================================
  // operand decode
  logic             take;
  logic [7:0]       m;
  logic             c_in;
  logic [8:0]       diff;
  logic [4:0]       nib;
  logic [7:0]       sub_res;
  logic             sub_wrap;
  logic [7:0]       next_work;
  rrsa_flags_t      next_flags;
  logic [7:0]       rot_plain;
  logic [7:0]       rot_carry;

  // a load from the core wins over a request in the same cycle
  assign take = req.valid && !load.valid;
  assign m    = req.mem_data;
  assign c_in = flags.carry_flag;

  assign rot_plain = {m[0], m[MSB:1]};                          // RULE_01
  assign rot_carry = {c_in, m[MSB:1]};                          // RULE_04

  // nine bits so the top bit is the borrow out of bit 7
  assign diff    = {1'b0, work_reg} - {1'b0, m} - {8'h00, ~c_in}; // RULE_07
  assign nib     = {1'b0, work_reg[NIB_W-1:0]} - {1'b0, m[NIB_W-1:0]}
                   - {4'h0, ~c_in};
  assign sub_res = diff[DATA_W-1:0];
  assign sub_wrap = (work_reg[MSB] ^ m[MSB]) & (work_reg[MSB] ^ sub_res[MSB]);

  // ==========================================================
  // result select
  always_comb begin
    next_work  = work_reg;
    next_flags = flags;
    if (take) begin
      unique case (req.op)
        RRSA_OP_ROT_WORK: begin
          next_work = rot_plain;                                // RULE_01 RULE_02
        end
        RRSA_OP_ROT_C_MEM: begin
          next_flags.carry_flag = m[0];                         // RULE_04
        end
        RRSA_OP_ROT_C_WORK: begin
          next_work             = rot_carry;                    // RULE_05
          next_flags.carry_flag = m[0];                         // RULE_06
        end
        RRSA_OP_SUB_BORROW: begin
          next_work                     = sub_res;              // RULE_07
          next_flags.carry_flag         = ~diff[DATA_W];        // RULE_08
          next_flags.nibble_borrow_flag = ~nib[NIB_W];          // RULE_09
          next_flags.zero_flag          = (sub_res == 8'h00);
          next_flags.arith_wrap_flag    = sub_wrap;
          next_flags.signed_result_flag = sub_wrap ^ sub_res[MSB];
          // nil chains across multi-byte subtracts: stays set only if
          // every byte so far came out zero
          next_flags.extended_nil_flag  = (sub_res == 8'h00)
                                          & flags.extended_nil_flag;
        end
        default: begin
        end
      endcase
    end else if (load.valid) begin
      next_work  = load.work;
      next_flags = load.flags;
    end
  end

  // ==========================================================
  // working register and flags
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      work_reg <= WORK_RST;
      flags    <= FLAGS_RST;
    end else if (clk_en) begin
      work_reg <= next_work;
      flags    <= next_flags;
    end
  end

  // ==========================================================
  // memory write-back, only the memory-destination rotate writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mem_wr <= '0;
    end else if (clk_en) begin
      mem_wr.valid <= take && (req.op == RRSA_OP_ROT_C_MEM);    // RULE_03
      mem_wr.data  <= rot_carry;                                // RULE_03
    end
  end

  // ==========================================================
  // checks
  sequence rot_work_s;
    clk_en && take && req.op == RRSA_OP_ROT_WORK;
  endsequence
  sequence rot_c_mem_s;
    clk_en && take && req.op == RRSA_OP_ROT_C_MEM;
  endsequence
  sequence rot_c_work_s;
    clk_en && take && req.op == RRSA_OP_ROT_C_WORK;
  endsequence
  sequence sub_s;
    clk_en && take && req.op == RRSA_OP_SUB_BORROW;
  endsequence

  plain_rot_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_01
    rot_work_s |=> work_reg == {$past(req.mem_data[0]),
                                $past(req.mem_data[7:1])})
    else $error("plain rotate result wrong");

  plain_keep_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_02
    rot_work_s |=> !mem_wr.valid && $stable(flags))
    else $error("plain rotate touched flags or memory");

  mem_write_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_03
    rot_c_mem_s |=> mem_wr.valid && $stable(work_reg))
    else $error("memory rotate did not write back");

  mem_bits_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_04
    rot_c_mem_s |=> mem_wr.data == {$past(flags.carry_flag),
                                    $past(req.mem_data[7:1])}
                    && flags.carry_flag == $past(req.mem_data[0])
                    && flags[5:1] == $past(flags[5:1]))
    else $error("memory rotate bits or carry wrong");

  work_c_rot_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_05
    rot_c_work_s |=> work_reg == {$past(flags.carry_flag),
                                  $past(req.mem_data[7:1])}
                     && flags.carry_flag == $past(req.mem_data[0]))
    else $error("carry rotate to work wrong");

  work_c_keep_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_06
    rot_c_work_s |=> !mem_wr.valid && flags[5:1] == $past(flags[5:1]))
    else $error("carry rotate to work moved other state");

  sub_value_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_07
    sub_s |=> work_reg == 8'($past(work_reg) - $past(req.mem_data)
                             - {7'h00, ~$past(flags.carry_flag)})
              && !mem_wr.valid)
    else $error("subtract result wrong");

  sub_carry_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_08
    sub_s |=> flags.carry_flag ==
      ({1'b0, $past(work_reg)} >= ({1'b0, $past(req.mem_data)}
                                   + {8'h00, ~$past(flags.carry_flag)})))
    else $error("subtract carry wrong");

  sub_zero_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_09
    sub_s |=> flags.zero_flag == (work_reg == 8'h00)
              && flags.signed_result_flag ==
                 (flags.arith_wrap_flag ^ work_reg[7]))
    else $error("subtract zero or signed flag wrong");

  // ==========================================================
  // hold, load and reset checks
  // these guard the core-facing controls rather than one instruction
  sequence frozen_s;
    !clk_en;
  endsequence
  sequence load_s;
    clk_en && load.valid;
  endsequence
  sequence bad_op_s;
    clk_en && take && req.op > RRSA_OP_SUB_BORROW;
  endsequence

  freeze_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    frozen_s |=> $stable(work_reg) && $stable(flags) && $stable(mem_wr))
    else $error("state moved while clock enable was low");

  load_wins_a: assert property (@(posedge sys_clk) disable iff (rst)
    load_s |=> work_reg == $past(load.work) && flags == $past(load.flags)
               && !mem_wr.valid)
    else $error("core load not applied");

  // unused codes must not disturb the working state
  bad_op_a: assert property (@(posedge sys_clk) disable iff (rst)
    bad_op_s |=> $stable(work_reg) && $stable(flags) && !mem_wr.valid)
    else $error("unused op code changed state");

  reset_clear_a: assert property (@(posedge sys_clk)
    rst |=> work_reg == WORK_RST && flags == FLAGS_RST && !mem_wr.valid)
    else $error("reset did not clear state");

endmodule
`default_nettype wire

// ==== hdl/rrsa_pkg.sv ====
/*
  package for the rotate-right / subtract-with-borrow datapath:
  operation codes, flag layout and the request/answer carriers.
  assumes an 8-bit core.
*/
package rrsa_pkg;

  localparam int unsigned DATA_W  = 8;
  localparam int unsigned NIB_W   = 4;
  localparam int unsigned MSB     = 7;
  localparam logic [7:0] WORK_RST = 8'h00;

  // flag field positions inside rrsa_flags_t
  localparam int unsigned FLG_CARRY  = 0;
  localparam int unsigned FLG_NIBBLE = 1;
  localparam int unsigned FLG_ZERO   = 2;
  localparam int unsigned FLG_WRAP   = 3;
  localparam int unsigned FLG_SIGNED = 4;
  localparam int unsigned FLG_NIL    = 5;
  localparam logic [5:0] FLAGS_RST   = 6'h00;

  typedef enum logic [2:0] {
    RRSA_OP_NOP         = 3'b000,
    RRSA_OP_ROT_WORK    = 3'b001,
    RRSA_OP_ROT_C_MEM   = 3'b010,
    RRSA_OP_ROT_C_WORK  = 3'b011,
    RRSA_OP_SUB_BORROW  = 3'b100
  } rrsa_op_t;

  typedef struct packed {
    logic extended_nil_flag;
    logic signed_result_flag;
    logic arith_wrap_flag;
    logic zero_flag;
    logic nibble_borrow_flag;
    logic carry_flag;
  } rrsa_flags_t;

  typedef struct packed {
    logic       valid;
    rrsa_op_t   op;
    logic [7:0] mem_data;
  } rrsa_req_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  work;
    rrsa_flags_t flags;
  } rrsa_load_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rrsa_mem_wr_t;

endpackage

// ==== verif/tb.sv ====
/*
  self-checking bench for rrsa_alu: rotates and subtract-with-borrow.
  assumes the package rrsa_pkg and one sys_clk domain at 100 MHz.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import rrsa_pkg::*;
  logic         sys_clk;
  logic         rst;
  logic         clk_en;
  rrsa_req_t    req;
  rrsa_load_t   load;
  logic [7:0]   work_reg;
  rrsa_flags_t  flags;
  rrsa_mem_wr_t mem_wr;
  int           error_cnt;
  int           samples_checked;
  int           cycles;

  rrsa_alu dut (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .req      (req),
    .load     (load),
    .work_reg (work_reg),
    .flags    (flags),
    .mem_wr   (mem_wr)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // compare and closing
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_flags(input rrsa_flags_t got, input rrsa_flags_t exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t flags got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // drivers: the request is taken at the second edge of issue
  task automatic preload(input logic [7:0] w, input rrsa_flags_t f);
    @(posedge sys_clk);
    load <= '{1'b1, w, f};
    @(posedge sys_clk);
    load.valid <= 1'b0;
  endtask

  task automatic issue(input rrsa_op_t op, input logic [7:0] m);
    @(posedge sys_clk);
    req <= '{1'b1, op, m};
    @(posedge sys_clk);
    req.valid <= 1'b0;
    #1;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_rot_work;
    // carry 0 so a carry-fed bit 7 would show as 40
    preload(8'h5A, 6'h3E);
    issue(RRSA_OP_ROT_WORK, 8'h81);
    chk_byte(work_reg, 8'hC0);
    chk_flags(flags, 6'h3E);
    chk_byte({7'h00, mem_wr.valid}, 8'h00);
  endtask

  task automatic t_rot_mem;
    preload(8'h5A, 6'h3E);
    issue(RRSA_OP_ROT_C_MEM, 8'h81);
    chk_byte({7'h00, mem_wr.valid}, 8'h01);
    chk_byte(mem_wr.data, 8'h40);
    chk_flags(flags, 6'h3F);
    chk_byte(work_reg, 8'h5A);
    // after one idle cycle: the new carry feeds the next rotate
    issue(RRSA_OP_ROT_C_MEM, 8'h02);
    chk_byte(mem_wr.data, 8'h81);
    chk_flags(flags, 6'h3E);
  endtask

  task automatic t_rot_c_work;
    preload(8'h00, 6'h3F);
    issue(RRSA_OP_ROT_C_WORK, 8'h02);
    chk_byte(work_reg, 8'h81);
    chk_flags(flags, 6'h3E);
    chk_byte({7'h00, mem_wr.valid}, 8'h00);
  endtask

  task automatic t_sub;
    logic [23:0] cases [5];
    logic [8:0]  d;
    logic [4:0]  n;
    rrsa_flags_t f;
    cases = '{24'h10_2001, 24'h05_0400, 24'h80_0101, 24'h7F_FF01,
              24'h13_0401};
    foreach (cases[i]) begin
      d = {1'b0, cases[i][23:16]} - {1'b0, cases[i][15:8]}
          - {8'h00, ~cases[i][0]};
      n = {1'b0, cases[i][19:16]} - {1'b0, cases[i][11:8]}
          - {4'h0, ~cases[i][0]};
      f.carry_flag         = ~d[8];
      f.nibble_borrow_flag = ~n[4];
      f.zero_flag          = (d[7:0] == 8'h00);
      f.arith_wrap_flag    = (cases[i][23] ^ cases[i][15])
                             & (cases[i][23] ^ d[7]);
      f.signed_result_flag = f.arith_wrap_flag ^ d[7];
      f.extended_nil_flag  = f.zero_flag;
      preload(cases[i][23:16], {5'h10, cases[i][0]});
      issue(RRSA_OP_SUB_BORROW, cases[i][15:8]);
      chk_byte(work_reg, d[7:0]);
      chk_flags(flags, f);
      chk_byte({7'h00, mem_wr.valid}, 8'h00);
    end
  endtask

  task automatic t_hold;
    preload(8'h3C, 6'h21);
    // a load in the same cycle as a request wins
    @(posedge sys_clk);
    req  <= '{1'b1, RRSA_OP_ROT_WORK, 8'h81};
    load <= '{1'b1, 8'h96, 6'h12};
    @(posedge sys_clk);
    req.valid  <= 1'b0;
    load.valid <= 1'b0;
    #1;
    chk_byte(work_reg, 8'h96);
    chk_flags(flags, 6'h12);
    // clock enable low freezes a pending request
    @(posedge sys_clk);
    clk_en <= 1'b0;
    req    <= '{1'b1, RRSA_OP_ROT_C_MEM, 8'h81};
    repeat (2) @(posedge sys_clk);
    clk_en    <= 1'b1;
    req.valid <= 1'b0;
    #1;
    chk_byte(work_reg, 8'h96);
    chk_flags(flags, 6'h12);
    chk_byte({7'h00, mem_wr.valid}, 8'h00);
    // an unused op code changes nothing
    issue(rrsa_op_t'(3'b111), 8'hFF);
    chk_byte(work_reg, 8'h96);
    chk_flags(flags, 6'h12);
    chk_byte({7'h00, mem_wr.valid}, 8'h00);
  endtask

  // ==========================================================
  // hang guard: the whole run needs well under 200 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    req = '0;
    load = '0;
    error_cnt = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk_byte(work_reg, 8'h00);
    chk_flags(flags, 6'h00);
    t_rot_work();
    t_rot_mem();
    t_rot_c_work();
    t_sub();
    t_hold();
    conclude();
  end
endmodule

`default_nettype wire
